// ==== verilog/afsr_fault_regs.sv ====
`timescale 1ns/1ns
`include "afsr_params.svh"

// What this block does
// - The low two bits at offset 0x01 select the 8.4, 12.6, 14 or 15 V full-scale analog mapping.
// - Digital volume moves in 0.375 dB steps from +24 dB down to -70 dB.
// - Bit 6 of the fault status shows the 5 V regulator fell below 3.6 V.
// - Fault status at 0x0A shows limiter bit 5, clipping bit 4, overcurrent bit 3, overheat bit 2, battery bit 0.
// - Bits 7:6 at 0x0B choose the gain cut applied while the heat warning is active.
// - Bit 5 at 0x0B is written by the host to request a recovery attempt.
// - Bits 4:3 at 0x0B set how many automatic recovery attempts are made.
// - Bits 2, 1, 0 at 0x0B pick automatic or manual recovery for undervoltage, overheat, overcurrent.
// - Automatic recovery retries, flags again while the fault lasts, and repeats until it clears or the attempt limit is used up.
// - Manual recovery keeps the stage shut down until the host requests an attempt.
// - The 8-bit battery conversion is stored unsigned and read at 0x06.
// - Battery code 0 means 3.8 V and code 255 means 16.2 V, linear between.
// - The battery knee threshold is an 8-bit value on the same 3.8 to 16.2 V scale.
module afsr_fault_regs #(
  parameter int RETRY_CYCLES = `AFSR_RETRY_CYC
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic       uvFaultPin,
  input  wire logic       otFaultPin,
  input  wire logic       ocFaultPin,
  input  wire logic       limiterPin,
  input  wire logic       clipPin,
  input  wire logic       heatWarnPin,
  input  wire logic [7:0] batCodePin,
  input  wire logic       batValidPin,
  output logic      [1:0] analogRangeSel,
  output logic      [8:0] volumeGain,
  output logic      [1:0] heatAttenuation,
  output logic            ampShutdown
);

  logic [14:0] pinMeta_q, pinSync_q;
  logic [14:0] pinRaw;
  logic [1:0]  gain_q, gain_d;
  logic [7:0]  vol_q, vol_d;
  logic [7:0]  knee_q, knee_d;
  logic [7:0]  recov_q, recov_d;
  logic        manPulse_q, manPulse_d;
  logic [7:0]  batCode_q, batCode_d;
  logic        batValid_q;
  logic [7:0]  rdData_q, rdData_d;
  logic [7:0]  rdMux;
  logic [7:0]  faultByte;
  logic [8:0]  volGain_q, volGain_d;
  logic [1:0]  heatAtt_q, heatAtt_d;
  logic        shut_q, shut_d;
  logic        batAbove;
  logic        uvS, otS, ocS, limS, clipS, warnS, batVS;
  logic [7:0]  batS;

  afsr_rec_if recIf ();

  // every pin level passes two flops; the first stage feeds only the second
  assign pinRaw = {batValidPin, batCodePin, heatWarnPin, clipPin, limiterPin, ocFaultPin, otFaultPin, uvFaultPin};
  always_ff @(posedge clk) begin
    if (srst) begin
      pinMeta_q <= 15'h0000;
      pinSync_q <= 15'h0000;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
    end
  end

  assign uvS   = pinSync_q[0];
  assign otS   = pinSync_q[1];
  assign ocS   = pinSync_q[2];
  assign limS  = pinSync_q[3];
  assign clipS = pinSync_q[4];
  assign warnS = pinSync_q[5];
  assign batS  = pinSync_q[13:6];
  assign batVS = pinSync_q[14];

  // recovery channels: index 0 overcurrent, 1 overheat, 2 undervoltage
  assign recIf.faultLvl    = {uvS, otS, ocS};
  assign recIf.autoEn      = recov_q[2:0];
  assign recIf.retryLimit  = recov_q[`AFSR_RC_TRY_HI:`AFSR_RC_TRY_LO];
  assign recIf.manualPulse = manPulse_q;

  afsr_recovery #(
    .RETRY_CYCLES (RETRY_CYCLES)
  ) u_recovery (
    .clk   (clk),
    .srst  (srst),
    .recIf (recIf)
  );

  // knee comparison on the shared 3.8 to 16.2 V code scale
  assign batAbove = (batCode_q > knee_q);

  // shared bit 4 carries clipping and the heat warning together
  assign faultByte = {1'b0, recIf.flagOn[2], limS, clipS | warnS, recIf.flagOn[0], recIf.flagOn[1], 1'b0, batAbove};

  // read decode; unmapped offsets read zero
  always_comb begin
    if (regAddr == `AFSR_OFFS_GAIN) rdMux = {6'h00, gain_q};
    else if (regAddr == `AFSR_OFFS_VOL) rdMux = vol_q;
    else if (regAddr == `AFSR_OFFS_BATV) rdMux = batCode_q;
    else if (regAddr == `AFSR_OFFS_KNEE) rdMux = knee_q;
    else if (regAddr == `AFSR_OFFS_FAULT) rdMux = faultByte;
    else if (regAddr == `AFSR_OFFS_RECOV) rdMux = recov_q;
    else rdMux = 8'h00;
  end

  // register writes, read capture and battery capture
  always_comb begin
    gain_d     = gain_q;
    vol_d      = vol_q;
    knee_d     = knee_q;
    recov_d    = recov_q;
    manPulse_d = 1'b0;
    rdData_d   = rdData_q;
    batCode_d  = batCode_q;
    if (regWrEn) begin
      if (regAddr == `AFSR_OFFS_GAIN) begin
        gain_d = regWrData[1:0];
      end else if (regAddr == `AFSR_OFFS_VOL) begin
        // codes past -70 dB would overrun the range, so they stick at the floor
        vol_d = (regWrData > `AFSR_VOL_MAX_CODE) ? `AFSR_VOL_MAX_CODE : regWrData;
      end else if (regAddr == `AFSR_OFFS_KNEE) begin
        knee_d = regWrData;
      end else if (regAddr == `AFSR_OFFS_RECOV) begin
        recov_d    = {regWrData[7:6], 1'b0, regWrData[4:0]};
        manPulse_d = regWrData[`AFSR_RC_MAN];
      end
      // writes to the fault status and battery offsets are dropped
    end
    if (regRdEn) rdData_d = rdMux;
    // converter holds its code across valid, so taking it on the valid edge is safe
    if (batVS && !batValid_q) batCode_d = batS;
  end

  // outputs derived from register state
  always_comb begin
    volGain_d = `AFSR_VOL_ZERO_DB - {1'b0, vol_q};
    heatAtt_d = warnS ? recov_q[`AFSR_RC_ATT_HI:`AFSR_RC_ATT_LO] : 2'h0;
    shut_d    = |recIf.shutdown;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      gain_q     <= `AFSR_RST_GAIN;
      vol_q      <= `AFSR_RST_VOL;
      knee_q     <= `AFSR_RST_KNEE;
      recov_q    <= `AFSR_RST_RECOV;
      manPulse_q <= 1'b0;
      rdData_q   <= 8'h00;
      batCode_q  <= 8'h00;
      batValid_q <= 1'b0;
      volGain_q  <= 9'h000;
      heatAtt_q  <= 2'h0;
      shut_q     <= 1'b0;
    end else begin
      gain_q     <= gain_d;
      vol_q      <= vol_d;
      knee_q     <= knee_d;
      recov_q    <= recov_d;
      manPulse_q <= manPulse_d;
      rdData_q   <= rdData_d;
      batCode_q  <= batCode_d;
      batValid_q <= batVS;
      volGain_q  <= volGain_d;
      heatAtt_q  <= heatAtt_d;
      shut_q     <= shut_d;
    end
  end

  assign regRdData       = rdData_q;
  assign analogRangeSel  = gain_q;
  assign volumeGain      = volGain_q;
  assign heatAttenuation = heatAtt_q;
  assign ampShutdown     = shut_q;

  range_write_a: assert property (@(posedge clk) disable iff (srst)
    (regWrEn && regAddr == `AFSR_OFFS_GAIN) |=> analogRangeSel == $past(regWrData[1:0]))
    else $error("analog range not taken from write");

  volume_bounds_a: assert property (@(posedge clk) disable iff (srst)
    (regWrEn && regAddr == `AFSR_OFFS_VOL && regWrData == 8'hFF) |=> ##1 volumeGain == 9'h146)
    else $error("volume floor not at -70 dB step");

  status_readonly_a: assert property (@(posedge clk) disable iff (srst)
    (regWrEn && regAddr == `AFSR_OFFS_FAULT) |=> $stable(gain_q) && $stable(vol_q) && $stable(knee_q) && $stable(recov_q))
    else $error("write to fault status changed state");

  resume_pulse_a: assert property (@(posedge clk) disable iff (srst)
    (regWrEn && regAddr == `AFSR_OFFS_RECOV && regWrData[`AFSR_RC_MAN]) |=> manPulse_q ##1 !manPulse_q && !recov_q[`AFSR_RC_MAN])
    else $error("recovery request not a single self-clearing pulse");

  heat_cut_a: assert property (@(posedge clk) disable iff (srst)
    warnS |=> heatAttenuation == $past(recov_q[`AFSR_RC_ATT_HI:`AFSR_RC_ATT_LO]))
    else $error("heat warning cut does not follow control bits");

  battery_flag_a: assert property (@(posedge clk) disable iff (srst)
    (regRdEn && regAddr == `AFSR_OFFS_FAULT) |=> regRdData[`AFSR_FLT_BAT] == $past(batCode_q > knee_q))
    else $error("battery flag wrong against knee");

  uv_flag_a: assert property (@(posedge clk) disable iff (srst)
    (regRdEn && regAddr == `AFSR_OFFS_FAULT) |=> regRdData[`AFSR_FLT_UV] == $past(recIf.flagOn[2]))
    else $error("undervoltage flag missing from status");

  bat_capture_a: assert property (@(posedge clk) disable iff (srst)
    (batVS && !batValid_q) |=> batCode_q == $past(batS))
    else $error("battery code not captured on valid");

endmodule : afsr_fault_regs

// ==== pkg/afsr_params.svh ====
`ifndef AFSR_PARAMS_SVH
`define AFSR_PARAMS_SVH

// clock rate and fault retry spacing
`define AFSR_CLK_MHZ       125
`define AFSR_RETRY_US      100
`define AFSR_RETRY_CYC     (`AFSR_RETRY_US * `AFSR_CLK_MHZ)

// register offsets
`define AFSR_OFFS_GAIN     8'h01
`define AFSR_OFFS_VOL      8'h03
`define AFSR_OFFS_BATV     8'h06
`define AFSR_OFFS_KNEE     8'h09
`define AFSR_OFFS_FAULT    8'h0A
`define AFSR_OFFS_RECOV    8'h0B

// fault status bit positions
`define AFSR_FLT_UV        6
`define AFSR_FLT_LIM       5
`define AFSR_FLT_CLIP      4
`define AFSR_FLT_OC        3
`define AFSR_FLT_OT        2
`define AFSR_FLT_BAT       0

// recovery control bit positions
`define AFSR_RC_ATT_HI     7
`define AFSR_RC_ATT_LO     6
`define AFSR_RC_MAN        5
`define AFSR_RC_TRY_HI     4
`define AFSR_RC_TRY_LO     3

// reset values
`define AFSR_RST_GAIN      2'h0
`define AFSR_RST_VOL       8'h40
`define AFSR_RST_KNEE      8'h00
`define AFSR_RST_RECOV     8'h07

// volume code: 0 is +24 dB, each code one 0.375 dB step down
`define AFSR_VOL_ZERO_DB   9'h040
`define AFSR_VOL_MAX_CODE  8'hFA

`endif

// ==== pkg/afsr_pkg.sv ====
package afsr_pkg;

  // per-fault recovery sequence
  typedef enum logic [1:0] {
    REC_RUN,
    REC_DOWN,
    REC_PROBE
  } afsr_rec_e;

  typedef logic [2:0] afsr_flt_t;

endpackage : afsr_pkg

// ==== pkg/afsr_rec_if.sv ====
`timescale 1ns/1ns
// fault channels in index order: 0 overcurrent, 1 overheat, 2 undervoltage
interface afsr_rec_if;
  afsr_pkg::afsr_flt_t faultLvl;
  afsr_pkg::afsr_flt_t autoEn;
  logic [1:0]          retryLimit;
  logic                manualPulse;
  afsr_pkg::afsr_flt_t shutdown;
  afsr_pkg::afsr_flt_t flagOn;

  modport ctrl (output faultLvl, output autoEn, output retryLimit, output manualPulse,
                input shutdown, input flagOn);
  modport rec  (input faultLvl, input autoEn, input retryLimit, input manualPulse,
                output shutdown, output flagOn);
endinterface : afsr_rec_if

// ==== verilog/afsr_recovery.sv ====
`timescale 1ns/1ns
`include "afsr_params.svh"

module afsr_recovery #(
  parameter int RETRY_CYCLES = `AFSR_RETRY_CYC
) (
  input wire logic clk,
  input wire logic srst,
  afsr_rec_if.rec  recIf
);

  localparam int TW = $clog2(RETRY_CYCLES + 1);
  localparam logic [TW-1:0] TLAST = TW'(RETRY_CYCLES - 1);

  genvar i;
  for (i = 0; i < 3; i++) begin : g_chan
    afsr_pkg::afsr_rec_e st_q, st_d;
    logic [TW-1:0]       tmr_q, tmr_d;
    logic [1:0]          tries_q, tries_d;
    logic                retryOk;

    // one shutdown sequence per fault; the probe window lets a persisting fault re-trip
    always_comb begin
      st_d    = st_q;
      tmr_d   = tmr_q;
      tries_d = tries_q;
      // limit code 0 retries without end, others cap the attempts per episode
      retryOk = recIf.autoEn[i] && ((recIf.retryLimit == 2'h0) || (tries_q < recIf.retryLimit));
      case (st_q)
        afsr_pkg::REC_RUN: begin
          if (recIf.faultLvl[i]) begin
            st_d  = afsr_pkg::REC_DOWN;
            tmr_d = '0;
          end
        end
        afsr_pkg::REC_DOWN: begin
          if (tmr_q != TLAST) tmr_d = tmr_q + 1'b1;
          if (recIf.manualPulse) begin
            st_d  = afsr_pkg::REC_PROBE;
            tmr_d = '0;
          end else if (retryOk && tmr_q == TLAST) begin
            st_d  = afsr_pkg::REC_PROBE;
            tmr_d = '0;
            if (tries_q != 2'h3) tries_d = tries_q + 2'h1;
          end
        end
        afsr_pkg::REC_PROBE: begin
          if (recIf.faultLvl[i]) begin
            st_d  = afsr_pkg::REC_DOWN;
            tmr_d = '0;
          end else if (tmr_q == TLAST) begin
            st_d    = afsr_pkg::REC_RUN;
            tries_d = 2'h0;
          end else begin
            tmr_d = tmr_q + 1'b1;
          end
        end
        default: st_d = afsr_pkg::REC_RUN;
      endcase
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        st_q    <= afsr_pkg::REC_RUN;
        tmr_q   <= '0;
        tries_q <= 2'h0;
      end else begin
        st_q    <= st_d;
        tmr_q   <= tmr_d;
        tries_q <= tries_d;
      end
    end

    // the stage stays off while down or probing is not needed: probing lets it run
    assign recIf.shutdown[i] = (st_q == afsr_pkg::REC_DOWN);
    assign recIf.flagOn[i]   = (st_q == afsr_pkg::REC_DOWN);

    manual_hold_a: assert property (@(posedge clk) disable iff (srst)
      (st_q == afsr_pkg::REC_DOWN && !recIf.autoEn[i] && !recIf.manualPulse)
        |=> st_q == afsr_pkg::REC_DOWN)
      else $error("manual channel left shutdown without a request");

    retrip_a: assert property (@(posedge clk) disable iff (srst)
      (st_q == afsr_pkg::REC_PROBE && recIf.faultLvl[i]) |=> recIf.flagOn[i])
      else $error("persisting fault did not set its flag again");
  end

endmodule : afsr_recovery

// ==== dv/afsr_host.sv ====
`timescale 1ns/1ns
// host side of the register port, one byte per strobe
module afsr_host (
  input  wire logic       clk,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrEn,
  output logic            regRdEn,
  input  wire logic [7:0] regRdData
);
  // idle bus at time zero; address, data and both strobes start low
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  // fields flip after the strobe so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk) #1;
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask : wr
  // read byte is valid the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk) #1;
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask : rd
endmodule : afsr_host

// ==== dv/tb_afsr_fault_regs.sv ====
`timescale 1ns/1ns
module tb_afsr_fault_regs;
  // short retry spacing keeps every episode a few dozen cycles
  localparam int RC = 8;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdat;
    logic [7:0] rexp;
  } afsr_row_s;
  localparam afsr_row_s ROWS [14] = '{
    '{8'h01, 8'h00, 8'h00}, '{8'h01, 8'h01, 8'h01}, '{8'h01, 8'h02, 8'h02}, '{8'h01, 8'h03, 8'h03},
    '{8'h03, 8'h00, 8'h00}, '{8'h03, 8'hFA, 8'hFA}, '{8'h03, 8'hFF, 8'hFA}, '{8'h03, 8'h40, 8'h40},
    '{8'h06, 8'h55, 8'h00}, '{8'h0A, 8'hFF, 8'h00}, '{8'h20, 8'h5A, 8'h00}, '{8'h09, 8'h80, 8'h80},
    '{8'h0B, 8'h3F, 8'h1F}, '{8'h0B, 8'hC7, 8'hC7}};
  localparam logic [7:0] LIVE [3] = '{8'h20, 8'h10, 8'h10};
  localparam logic [7:0] FLT  [3] = '{8'h08, 8'h04, 8'h40};
  localparam logic [7:0] RSTA [6] = '{8'h01, 8'h03, 8'h06, 8'h09, 8'h0A, 8'h0B};
  localparam logic [7:0] RSTE [6] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h07};
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrEn;
  logic       regRdEn;
  logic [7:0] regRdData;
  logic [2:0] fltPin = 3'h0;
  logic       limiterPin = 1'b0;
  logic       clipPin = 1'b0;
  logic       heatWarnPin = 1'b0;
  logic [7:0] batCodePin = 8'h00;
  logic       batValidPin = 1'b0;
  logic [1:0] analogRangeSel;
  logic [8:0] volumeGain;
  logic [1:0] heatAttenuation;
  logic       ampShutdown;
  logic [7:0] rv;
  logic [7:0] m;
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         falls;

  afsr_fault_regs #(.RETRY_CYCLES(RC)) i_afsr_fault_regs (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .uvFaultPin(fltPin[2]), .otFaultPin(fltPin[1]),
    .ocFaultPin(fltPin[0]), .limiterPin(limiterPin), .clipPin(clipPin), .heatWarnPin(heatWarnPin),
    .batCodePin(batCodePin), .batValidPin(batValidPin), .analogRangeSel(analogRangeSel),
    .volumeGain(volumeGain), .heatAttenuation(heatAttenuation), .ampShutdown(ampShutdown));
  afsr_host i_afsr_host (.clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData));

  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    i_afsr_host.rd(a, rv);
    chk({1'b0, rv}, {1'b0, e});
  endtask : rdchk
  // leaves inputs free to change just after an edge
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles
  // a fall of shutdown marks one retry that released the stage
  task automatic count_falls(input int n, output int f);
    logic p;
    f = 0;
    p = ampShutdown;
    repeat (n) begin
      @(posedge clk) #1;
      if (p === 1'b1 && ampShutdown === 1'b0) f++;
      p = ampShutdown;
    end
  endtask : count_falls
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // main sequence: table rows first, then reset and fault episodes
  initial begin
    cycles(3);
    srst = 1'b0;
    foreach (ROWS[i]) begin
      i_afsr_host.wr(ROWS[i].addr, ROWS[i].wdat);
      rdchk(ROWS[i].addr, ROWS[i].rexp);
      if (ROWS[i].addr == 8'h01) chk({7'h00, analogRangeSel}, {1'b0, ROWS[i].rexp});
      if (ROWS[i].addr == 8'h03) chk(volumeGain, 9'h040 - {1'b0, ROWS[i].rexp});
    end
    for (int i = 0; i < 3; i++) begin
      {limiterPin, clipPin, heatWarnPin} = 3'b100 >> i;
      cycles(6);
      rdchk(8'h0A, LIVE[i]);
      chk({7'h00, heatAttenuation}, (i == 2) ? 9'h003 : 9'h000);
    end
    {limiterPin, clipPin, heatWarnPin} = 3'b000;
    $display("test rows done");
    srst = 1'b1;
    cycles(2);
    srst = 1'b0;
    chk({6'h00, analogRangeSel, ampShutdown}, 9'h000);
    foreach (RSTA[i]) rdchk(RSTA[i], RSTE[i]);
    $display("test reset done");
    // converter code must stay put around the valid edge
    i_afsr_host.wr(8'h09, 8'h80);
    for (int i = 0; i < 2; i++) begin
      batCodePin = 8'h81 - 8'(i);
      cycles(2);
      batValidPin = 1'b1;
      cycles(6);
      batValidPin = 1'b0;
      rdchk(8'h06, 8'h81 - 8'(i));
      rdchk(8'h0A, 8'h01 - 8'(i));
    end
    $display("test battery done");
    for (int ch = 0; ch < 3; ch++) begin
      m = 8'h07 ^ (8'h01 << ch);
      i_afsr_host.wr(8'h0B, m);
      fltPin = 3'h1 << ch;
      cycles(10);
      rdchk(8'h0A, FLT[ch]);
      fltPin = 3'h0;
      cycles(3 * RC);
      chk({8'h00, ampShutdown}, 9'h001);
      i_afsr_host.wr(8'h0B, m | 8'h20);
      rdchk(8'h0B, m);
      cycles(RC + 6);
      chk({8'h00, ampShutdown}, 9'h000);
    end
    $display("test manual done");
    i_afsr_host.wr(8'h0B, 8'h07);
    fltPin = 3'h1;
    count_falls(6 * RC, falls);
    chk({8'h00, falls >= 2}, 9'h001);
    fltPin = 3'h0;
    cycles(3 * RC);
    chk({8'h00, ampShutdown}, 9'h000);
    i_afsr_host.wr(8'h0B, 8'h0F);
    fltPin = 3'h1;
    count_falls(6 * RC, falls);
    chk(9'(falls), 9'h001);
    fltPin = 3'h0;
    cycles(3 * RC);
    chk({8'h00, ampShutdown}, 9'h001);
    i_afsr_host.wr(8'h0B, 8'h2F);
    cycles(RC + 6);
    chk({8'h00, ampShutdown}, 9'h000);
    $display("test auto done");
    finish_test();
  end
endmodule : tb_afsr_fault_regs
